// ===== alt_regs.svh
// Purpose: Framing, opcode and timing constants of the altimeter port
// Assumes: Included by the port module, the host model and the testbench
// Notes:   Opcode and reset patterns are settable, not fixed by silicon
`ifndef ALT_REGS_SVH
`define ALT_REGS_SVH
`define ALT_START_LEN   5'd3
`define ALT_STOP_LEN    5'd3
`define ALT_SETUP_LEN   5'd4
`define ALT_ACK_CLKS    5'd2
`define ALT_READ_CLKS   5'd17
`define ALT_RST_PATTERN 21'h155540
`define ALT_OP_PRESSURE 4'hA
`define ALT_OP_TEMP     4'h9
`define ALT_OP_CAL1     4'h5
`define ALT_OP_CAL2     4'h6
`define ALT_OP_CAL3     4'h3
`define ALT_OP_CAL4     4'hC
`define ALT_CALIB_RESET 64'h0123_4567_89AB_CDEF
`define ALT_MCLK_HZ     32768
`define ALT_CONV_TICKS  1000
`endif

// ===== alt_pkg.sv
// Purpose: State types of the altimeter serial port
// Assumes: Constants come from alt_regs.svh
// Notes:   Types only
package alt_pkg;
  typedef enum logic [2:0] {
    ALT_IDLE  = 3'b000,
    ALT_SETUP = 3'b001,
    ALT_STOP  = 3'b010,
    ALT_ACK   = 3'b011,
    ALT_READ  = 3'b100
  } alt_link_state_t;

  typedef enum logic {
    ALT_CONV_IDLE = 1'b0,
    ALT_CONV_RUN  = 1'b1
  } alt_conv_state_t;
endpackage : alt_pkg

// ===== alt_port.sv
// Purpose: Three-wire command and readout port of the altimeter
// Assumes: Host drives serial_bit_clock; system clock is 100 MHz
// Notes:   Analog front end delivers results on the system clock
// Contract
// - Sample serial_in on bit clock rise
// - Launch serial_out on bit clock rise
// - Output carries result, calibration or status
// - Decode six instructions
// - Three high bits open every instruction
// - Three low bits close every setup
// - Four bits between frames form setup
// - Raise output on last stop bit of a conversion instruction
// - Clock held low; output falls at end
// - End-of-conversion edge is clean
// - Shift 16-bit result over 17 clocks
// - Readout position kept while clock halted
// - 21-bit reset pattern works anywhere
// - 64-bit calibration store is readable
// - Conversion timed by converter clock
// - Store splits into four 16-bit words
`timescale 1ns/1ps
`include "alt_regs.svh"
module alt_port
  import alt_pkg::*;
#(
  parameter int unsigned CONV_TICKS  = `ALT_CONV_TICKS,
  parameter logic [63:0] CALIB_STORE = `ALT_CALIB_RESET
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        serial_bit_clock,
  input  wire logic        serial_in,
  input  wire logic        converter_clock,
  input  wire logic [15:0] pressure_result,
  input  wire logic [15:0] temperature_result,
  output logic             serial_out
);
  // Counter below is 16 bits wide
  if (CONV_TICKS < 1 || CONV_TICKS > 65535)
  begin : g_bad_ticks
    $error("CONV_TICKS out of range");
  end
  // Link domain state
  alt_link_state_t state_r, state_nxt;
  logic [4:0]      cnt_r, cnt_nxt;
  logic [3:0]      code_r, code_nxt;
  logic [20:0]     hist_r, hist_nxt;
  logic            tgl_r, tgl_nxt;
  logic            temp_r, temp_nxt;
  logic            conv_r, conv_nxt;
  logic            dout_nxt;
  logic [15:0]     rd_word;
  logic            rst_hit, conv_op;
  // System domain state
  alt_conv_state_t cst_r, cst_nxt;
  logic [15:0]     tick_r, tick_nxt;
  logic [15:0]     result_r, result_nxt;
  logic            eoc_r, eoc_nxt;
  logic            ctemp_r, ctemp_nxt;
  logic            mclk_s1, mclk_s2, mclk_s3;
  logic            tgl_s1, tgl_s2, tgl_s3;
  logic            mclk_rise, conv_req;
  assign conv_op = (code_r == `ALT_OP_PRESSURE) || (code_r == `ALT_OP_TEMP);
  // Word to shift out; result_r is stable once the end pulse has fired
  always_comb
  begin
    if (conv_r)
      rd_word = result_r;
    else
    begin
      unique case (code_r)
        `ALT_OP_CAL1: rd_word = CALIB_STORE[63:48];
        `ALT_OP_CAL2: rd_word = CALIB_STORE[47:32];
        `ALT_OP_CAL3: rd_word = CALIB_STORE[31:16];
        `ALT_OP_CAL4: rd_word = CALIB_STORE[15:0];
        default:      rd_word = 16'h0000;
      endcase
    end
  end
  // Frame parser; every step happens on a bit clock rise
  always_comb
  begin
    hist_nxt  = {hist_r[19:0], serial_in};
    rst_hit   = (hist_nxt == `ALT_RST_PATTERN);
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    code_nxt  = code_r;
    tgl_nxt   = tgl_r;
    temp_nxt  = temp_r;
    conv_nxt  = conv_r;
    dout_nxt  = serial_out;
    unique case (state_r)
      ALT_IDLE:
      begin
        dout_nxt = 1'b0;
        if (!serial_in)
          cnt_nxt = 5'd0;
        else if (cnt_r == `ALT_START_LEN - 5'd1)
        begin
          state_nxt = ALT_SETUP;
          cnt_nxt   = 5'd0;
        end
        else
          cnt_nxt = cnt_r + 5'd1;
      end
      ALT_SETUP:
      begin
        code_nxt = {code_r[2:0], serial_in};
        cnt_nxt  = cnt_r + 5'd1;
        if (cnt_r == `ALT_SETUP_LEN - 5'd1)
        begin
          state_nxt = ALT_STOP;
          cnt_nxt   = 5'd0;
        end
      end
      ALT_STOP:
      begin
        cnt_nxt = cnt_r + 5'd1;
        if (serial_in)
        begin
          state_nxt = ALT_IDLE;
          cnt_nxt   = 5'd0;
        end
        else if (cnt_r == `ALT_STOP_LEN - 5'd1)
        begin
          cnt_nxt = 5'd0;
          unique case (code_r)
            `ALT_OP_PRESSURE, `ALT_OP_TEMP:
            begin
              state_nxt = ALT_ACK;
              dout_nxt  = 1'b1;
              tgl_nxt   = ~tgl_r;
              temp_nxt  = (code_r == `ALT_OP_TEMP);
              conv_nxt  = 1'b1;
            end
            `ALT_OP_CAL1, `ALT_OP_CAL2, `ALT_OP_CAL3, `ALT_OP_CAL4:
            begin
              state_nxt = ALT_READ;
              conv_nxt  = 1'b0;
            end
            default: state_nxt = ALT_IDLE;
          endcase
        end
      end
      ALT_ACK:
      begin
        // Host's two trailing clocks; output stays high
        cnt_nxt = cnt_r + 5'd1;
        if (cnt_r == `ALT_ACK_CLKS - 5'd1)
        begin
          state_nxt = ALT_READ;
          cnt_nxt   = 5'd0;
        end
      end
      ALT_READ:
      begin
        // Position lives in cnt_r, so a halted clock just pauses
        cnt_nxt = cnt_r + 5'd1;
        if (cnt_r == `ALT_READ_CLKS - 5'd1)
        begin
          state_nxt = ALT_IDLE;
          cnt_nxt   = 5'd0;
          dout_nxt  = 1'b0;
        end
        else
          dout_nxt = rd_word[4'(5'd15 - cnt_r)];
      end
    endcase
    if (rst_hit)
    begin
      state_nxt = ALT_IDLE;
      cnt_nxt   = 5'd0;
      dout_nxt  = 1'b0;
    end
  end
  // Link registers
  always_ff @(posedge serial_bit_clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ALT_IDLE;
      cnt_r   <= 5'd0;
      code_r  <= 4'h0;
      hist_r  <= 21'h000000;
      tgl_r   <= 1'b0;
      temp_r  <= 1'b0;
      conv_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      code_r  <= code_nxt;
      hist_r  <= hist_nxt;
      tgl_r   <= tgl_nxt;
      temp_r  <= temp_nxt;
      conv_r  <= conv_nxt;
    end
  end
  // Output flop; the end pulse clears it while the bit clock is stopped
  always_ff @(posedge serial_bit_clock or negedge resetn or posedge eoc_r)
  begin
    if (!resetn)
      serial_out <= 1'b0;
    else if (eoc_r)
      serial_out <= 1'b0;
    else
      serial_out <= dout_nxt;
  end
  // Synchronisers into the system domain
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      tgl_s1  <= 1'b0;
      tgl_s2  <= 1'b0;
      tgl_s3  <= 1'b0;
    end
    else
    begin
      mclk_s1 <= converter_clock;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      tgl_s1  <= tgl_r;
      tgl_s2  <= tgl_s1;
      tgl_s3  <= tgl_s2;
    end
  end
  assign mclk_rise = mclk_s2 & ~mclk_s3;
  assign conv_req  = tgl_s2 ^ tgl_s3;
  // Conversion timer; temp_r is settled before its toggle arrives
  always_comb
  begin
    cst_nxt    = cst_r;
    tick_nxt   = tick_r;
    result_nxt = result_r;
    ctemp_nxt  = ctemp_r;
    eoc_nxt    = 1'b0;
    unique case (cst_r)
      ALT_CONV_IDLE:
        if (conv_req)
        begin
          cst_nxt   = ALT_CONV_RUN;
          tick_nxt  = 16'h0000;
          ctemp_nxt = temp_r;
        end
      ALT_CONV_RUN:
        if (mclk_rise)
        begin
          tick_nxt = tick_r + 16'h0001;
          if (tick_r == 16'(CONV_TICKS - 1))
          begin
            cst_nxt    = ALT_CONV_IDLE;
            result_nxt = ctemp_r ? temperature_result : pressure_result;
            eoc_nxt    = 1'b1;
          end
        end
    endcase
  end
  // System registers; eoc_r is a flop so the clear carries no glitch
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cst_r    <= ALT_CONV_IDLE;
      tick_r   <= 16'h0000;
      result_r <= 16'h0000;
      ctemp_r  <= 1'b0;
      eoc_r    <= 1'b0;
    end
    else
    begin
      cst_r    <= cst_nxt;
      tick_r   <= tick_nxt;
      result_r <= result_nxt;
      ctemp_r  <= ctemp_nxt;
      eoc_r    <= eoc_nxt;
    end
  end
  // Link domain checks
  chk_start_frame: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    (state_r == ALT_IDLE && cnt_r == 5'd2 && serial_in && !rst_hit)
    |=> state_r == ALT_SETUP)
    else $error("start frame not taken");
  chk_stop_broken: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    (state_r == ALT_STOP && serial_in) |=> state_r == ALT_IDLE)
    else $error("high stop bit not rejected");
  chk_ack_rise: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    (state_r == ALT_STOP && cnt_r == 5'd2 && !serial_in && conv_op
     && !rst_hit) |=> (serial_out && state_r == ALT_ACK))
    else $error("conversion not acknowledged");
  chk_bad_code: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    (state_r == ALT_STOP && cnt_r == 5'd2 && !serial_in && !conv_op
     && code_r inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'h8, 4'hB,
                       4'hD, 4'hE, 4'hF})
    |=> (state_r == ALT_IDLE && !serial_out))
    else $error("unknown code not ignored");
  chk_msb_first: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    (state_r == ALT_READ && cnt_r == 5'd0 && !rst_hit)
    |=> serial_out == $past(rd_word[15]))
    else $error("readout not msb first");
  chk_read_len: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    (state_r == ALT_READ && cnt_r == 5'd16)
    |=> (state_r == ALT_IDLE && !serial_out))
    else $error("readout length wrong");
  chk_rst_any: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    rst_hit |=> (state_r == ALT_IDLE && cnt_r == 5'd0))
    else $error("reset pattern missed");
  // System domain checks
  chk_conv_start: assert property (
    @(posedge clock) disable iff (!resetn)
    (cst_r == ALT_CONV_IDLE && conv_req)
    |=> (cst_r == ALT_CONV_RUN && tick_r == 16'h0000))
    else $error("conversion not started");
  chk_eoc_pulse: assert property (
    @(posedge clock) disable iff (!resetn)
    $rose(eoc_r) |=> (!eoc_r && cst_r == ALT_CONV_IDLE))
    else $error("end pulse not single");
endmodule : alt_port

// ===== alt_host_model.sv
// Purpose: Host side of the three-wire altimeter port
// Assumes: Bit clock period 32 ns, clock idle low outside frames
// Notes:   Tasks are called by the testbench through the instance
`timescale 1ns/1ps
`include "alt_regs.svh"
module alt_host_model
(
  output logic      serial_bit_clock,
  output logic      serial_in,
  input  wire logic serial_out
);
  // Clock stands still until a task clocks a bit
  initial
  begin
    serial_bit_clock = 1'b0;
    serial_in        = 1'b0;
  end

  // Data set at the fall, output taken just before the next fall
  task automatic bit_cycle(input logic d, output logic q);
    serial_in = d;
    #16 serial_bit_clock = 1'b1;
    #16 q = serial_out;
    serial_bit_clock = 1'b0;
  endtask : bit_cycle

  task automatic send_instr(input logic [3:0] code, output logic ack);
    logic q;
    repeat (3) bit_cycle(1'b1, q);
    for (int i = 3; i >= 0; i--) bit_cycle(code[i], q);
    repeat (3) bit_cycle(1'b0, q);
    ack = q;
  endtask : send_instr

  // Shift in n bits; a stall after bit hold_at tests resumption
  task automatic clocks(input int n, input int hold_at,
                        output logic [16:0] v);
    logic q;
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      bit_cycle(1'b0, q);
      v = {v[15:0], q};
      if (i == hold_at) #500;
    end
  endtask : clocks

  // Output is ignored while the pattern goes out
  task automatic send_reset();
    logic [20:0] pat;
    logic        q;
    pat = `ALT_RST_PATTERN;
    for (int i = 20; i >= 0; i--)
      bit_cycle(pat[i], q);
  endtask : send_reset

  task automatic convert(input logic [3:0] code, input int hold_at,
                         output logic ack, output logic [1:0] hi,
                         output int waited, output logic glitch,
                         output logic [16:0] v);
    send_reset();
    send_instr(code, ack);
    bit_cycle(1'b0, hi[1]);
    bit_cycle(1'b0, hi[0]);
    waited = 0;
    while (serial_out !== 1'b0 && waited < 40000)
    begin
      #10;
      waited++;
    end
    #100 glitch = serial_out;
    clocks(17, hold_at, v);
  endtask : convert
endmodule : alt_host_model

// ===== alt_port_tb.sv
// Purpose: Self-checking bench of the altimeter serial port
// Assumes: Converter clock near 32.768 kHz, shortened conversion
// Notes:   Host model runs unrelated in phase to the system clock
`timescale 1ns/1ps
`include "alt_regs.svh"
module alt_port_tb;
  localparam int unsigned CONV_TICKS = 4;
  logic        clock;
  logic        resetn;
  logic        converter_clock;
  logic [15:0] pressure_result;
  logic [15:0] temperature_result;
  logic        serial_bit_clock;
  logic        serial_in;
  logic        serial_out;
  int          fail_count = 0;
  int          tests_run = 0;

  alt_port #(.CONV_TICKS(CONV_TICKS)) u_dut (
    .clock(clock), .resetn(resetn), .serial_bit_clock(serial_bit_clock),
    .serial_in(serial_in), .converter_clock(converter_clock),
    .pressure_result(pressure_result),
    .temperature_result(temperature_result), .serial_out(serial_out));
  alt_host_model u_host (.serial_bit_clock(serial_bit_clock),
    .serial_in(serial_in), .serial_out(serial_out));

  // System and converter clocks
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    converter_clock = 1'b0;
    forever #15259 converter_clock = ~converter_clock;
  end

  task automatic chk(input string name, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", name, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // All four words, one read stalled half way
  task automatic t_calib();
    logic [3:0]  op [4] = '{`ALT_OP_CAL1, `ALT_OP_CAL2,
                            `ALT_OP_CAL3, `ALT_OP_CAL4};
    logic [63:0] cal = `ALT_CALIB_RESET;
    logic        a;
    logic [16:0] v;
    logic [15:0] w;
    for (int i = 0; i < 4; i++)
    begin
      u_host.send_instr(op[i], a);
      chk("cal_ack", 16'h0000, a);
      u_host.clocks(17, (i == 2) ? 7 : 99, v);
      w = cal[63-16*i -: 16];
      chk("cal_word", w, v[16:1]);
      chk("cal_tail", 16'h0000, v[0]);
    end
  endtask : t_calib

  task automatic t_unknown();
    logic        a;
    logic [16:0] v;
    u_host.send_instr(4'h0, a);
    u_host.clocks(17, 99, v);
    chk("nop_out", 16'h0000, {15'h0000, a} | v[15:0]);
    // A high stop bit must abort a word one read
    for (int i = 0; i < 9; i++)
      u_host.bit_cycle(i < 3 || i == 4 || i == 6 || i == 8, a);
    u_host.clocks(17, 99, v);
    chk("stop_bad", 16'h0000, v[16:1]);
  endtask : t_unknown

  task automatic t_conv(input logic [3:0] code, input logic [15:0] e);
    logic        a;
    logic        gl;
    logic [1:0]  hi;
    int          w;
    logic [16:0] v;
    u_host.convert(code, 5, a, hi, w, gl, v);
    chk("conv_ack", 16'h0001, a);
    chk("conv_hold", 16'h0003, hi);
    // Waiting starts 80 ns after the acknowledge rise
    chk("conv_time", 16'h0001,
        w < 40000 && w * 10 + 80 >= (CONV_TICKS - 1) * 30518);
    chk("eoc_clean", 16'h0000, gl);
    chk("result", e, v[16:1]);
    chk("res_tail", 16'h0000, v[0]);
  endtask : t_conv

  // Reset pattern in mid readout, then a normal read
  task automatic t_reset_mid();
    logic        a;
    logic [16:0] v;
    u_host.send_instr(`ALT_OP_CAL4, a);
    u_host.clocks(5, 99, v);
    u_host.send_reset();
    chk("rst_out", 16'h0000, serial_out);
    u_host.send_instr(`ALT_OP_CAL2, a);
    u_host.clocks(17, 99, v);
    chk("rst_word", 16'h4567, v[16:1]);
  endtask : t_reset_mid

  // Main sequence
  initial
  begin
    resetn             = 1'b0;
    pressure_result    = 16'hA5C3;
    temperature_result = 16'h3C5A;
    repeat (6) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clock);
    chk("idle_out", 16'h0000, serial_out);
    t_calib();
    t_unknown();
    t_conv(`ALT_OP_PRESSURE, 16'hA5C3);
    t_conv(`ALT_OP_TEMP, 16'h3C5A);
    t_reset_mid();
    end_sim();
  end

  // Run takes about 230 us; this cuts a hang short
  initial
  begin
    #900000;
    fail_count++;
    end_sim();
  end
endmodule : alt_port_tb
